// ===== rtl/sadc_top.sv
// Contract
// [RQ1] eight channels, one converted, 10-bit value
// [RQ2] conversions start only by software register write
// [RQ3] enabled: back-to-back conversions, interrupt each
// [RQ4] resolve MSB first, transfer after LSB
// [RQ5] 16-bit result, left aligned, low six zero
// [RQ6] every completion reloads the result register
// [RQ7] reset clears the result register
// [RQ8] result read-only, read as one 16-bit word
// [RQ9] input held frozen during bit decisions
// [RQ10] mode bit 7 enables or disables conversion
// [RQ11] time code sets 144..48 clocks, two prohibited
// [RQ12] mode register resets zero, bits 6,2..0 zero
// [RQ13] software avoids fast codes at 10 MHz
// [RQ14] software discards first result after enabling
// [RQ15] result may be invalid after disable race
// [RQ16] select register picks channel, resets to zero
// [RQ17] select bits 2..0 binary channel, rest zero
// [RQ18] control write aborts, restarts if still enabled
// [RQ19] write beats completion: no load, no interrupt
// [RQ20] ten comparison steps, bit 9 down to 0
// [RQ21] clock counter from time code paces phases
// [RQ22] interrupt is one-cycle pulse with result load
`timescale 1ns/10ps
module sadc_top (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // cpu register port
  input  wire logic [15:0] addr_i,
  input  wire logic        wr_en_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        rd_en_i,
  output logic      [15:0] rdata_o,
  // analog front end
  output logic      [2:0]  analog_input_channels_o,
  output logic             sample_o,
  output logic             hold_o,
  output logic      [9:0]  tap_code_o,
  input  wire logic        cmp_i,
  // events
  output logic             conversion_done_irq_o,
  // result stream
  output logic             result_valid_o,
  output logic      [15:0] result_data_o,
  input  wire logic        result_ready_i
);

  typedef struct packed {
    logic [7:0]         mode;
    logic [2:0]         sel;
    logic [15:0]        result;
    sadc_pkg::sadc_state_e st;
    logic [4:0]         cnt;
    logic [3:0]         bit_idx;
    logic [9:0]         approximation_register;
    logic               irq;
    logic [15:0]        rdata;
    logic               sample;
    logic               hold;
  } sadc_top_s;

  sadc_top_s q;
  sadc_top_s next_q;
  logic      push;
  logic      fifo_in_ready;
  logic      wr_mode;
  logic      wr_sel;

  assign wr_mode = wr_en_i && (addr_i == sadc_pkg::MODE_ADDR);
  assign wr_sel  = wr_en_i && (addr_i == sadc_pkg::SEL_ADDR);

  // ---------------------------------------------------------------
  // sequencer and registers
  // ---------------------------------------------------------------
  always_comb begin
    logic [9:0] dec;
    logic [2:0] code;
    logic [3:0] slice;
    dec    = q.approximation_register;
    next_q = q;
    push   = 1'b0;
    code   = q.mode[sadc_pkg::TSEL_MSB:sadc_pkg::TSEL_LSB];
    slice  = sadc_pkg::sadc_slice_len(code); // see [RQ11]
    next_q.irq = 1'b0;

    unique case (q.st)
      sadc_pkg::SADC_IDLE: begin
        next_q.st = sadc_pkg::SADC_IDLE; // see [RQ2]
      end
      sadc_pkg::SADC_SAMPLE: begin
        if (q.cnt == 5'h00) begin
          next_q.st      = sadc_pkg::SADC_CONVERT; // see [RQ9]
          next_q.cnt     = 5'({1'b0, slice} - 5'h01); // see [RQ21]
          next_q.bit_idx = sadc_pkg::SAR_TOP_BIT; // see [RQ4]
          next_q.approximation_register     = sadc_pkg::SAR_FIRST_TRIAL;
        end else begin
          next_q.cnt = 5'(q.cnt - 5'h01);
        end
      end
      sadc_pkg::SADC_CONVERT: begin
        if (q.cnt != 5'h00) begin
          next_q.cnt = 5'(q.cnt - 5'h01);
        end else begin
          if (!cmp_i) begin
            dec[q.bit_idx] = 1'b0; // see [RQ20]
          end
          if (q.bit_idx == 4'h0) begin
            // full result buffer holds the last decision until room appears
            if (fifo_in_ready) begin
              next_q.result = {dec, 6'h00}; // see [RQ5] see [RQ6]
              next_q.irq    = 1'b1; // see [RQ22]
              push          = 1'b1;
              next_q.approximation_register    = dec;
              next_q.st     = sadc_pkg::SADC_SAMPLE; // see [RQ3]
              next_q.cnt    = 5'({1'b0, slice} * {1'b0, sadc_pkg::SAMPLE_SLICES} - 5'h01);
            end
          end else begin
            dec[4'(q.bit_idx - 4'h1)] = 1'b1; // see [RQ4]
            next_q.approximation_register     = dec;
            next_q.bit_idx = 4'(q.bit_idx - 4'h1);
            next_q.cnt     = 5'({1'b0, slice} - 5'h01);
          end
        end
      end
      default: begin
        next_q.st = sadc_pkg::SADC_IDLE;
      end
    endcase

    // control writes win over a completion in the same cycle
    if (wr_mode || wr_sel) begin
      if (wr_mode) begin
        next_q.mode = wdata_i & sadc_pkg::MODE_WR_MASK; // see [RQ12]
      end
      if (wr_sel) begin
        next_q.sel = wdata_i[sadc_pkg::SEL_MSB:0]; // see [RQ17]
      end
      next_q.irq     = 1'b0; // see [RQ19]
      next_q.result  = q.result;
      push           = 1'b0;
      next_q.approximation_register     = 10'h000;
      next_q.bit_idx = 4'h0;
      code  = next_q.mode[sadc_pkg::TSEL_MSB:sadc_pkg::TSEL_LSB];
      slice = sadc_pkg::sadc_slice_len(code);
      // two sample slices of the slowest code need five counter bits
      next_q.cnt = 5'({1'b0, slice} * {1'b0, sadc_pkg::SAMPLE_SLICES} - 5'h01);
      if (next_q.mode[sadc_pkg::ENABLE_BIT]) begin
        next_q.st = sadc_pkg::SADC_SAMPLE; // see [RQ18] see [RQ10]
      end else begin
        next_q.st = sadc_pkg::SADC_IDLE; // see [RQ10]
      end
    end

    next_q.sample = (next_q.st == sadc_pkg::SADC_SAMPLE);
    next_q.hold   = (next_q.st == sadc_pkg::SADC_CONVERT); // see [RQ9]

    // read returns the value held before any same-cycle update
    if (rd_en_i) begin
      unique case (addr_i)
        sadc_pkg::RESULT_ADDR: next_q.rdata = q.result; // see [RQ8]
        sadc_pkg::MODE_ADDR:   next_q.rdata = {8'h00, q.mode};
        sadc_pkg::SEL_ADDR:    next_q.rdata = {13'h0000, q.sel}; // see [RQ16]
        default:               next_q.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q        <= '0;
      q.mode   <= sadc_pkg::MODE_RESET;
      q.sel    <= sadc_pkg::SEL_RESET;
      q.result <= sadc_pkg::RESULT_RESET; // see [RQ7]
      q.st     <= sadc_pkg::SADC_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // ---------------------------------------------------------------
  // result buffer
  // ---------------------------------------------------------------
  sadc_fifo #(
    .WIDTH (sadc_pkg::FIFO_WIDTH),
    .DEPTH (sadc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push),
    .in_data_i   (next_q.result),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (result_valid_o),
    .out_data_o  (result_data_o),
    .out_ready_i (result_ready_i)
  );

  assign rdata_o                 = q.rdata;
  assign analog_input_channels_o = q.sel; // see [RQ1]
  assign sample_o                = q.sample;
  assign hold_o                  = q.hold;
  assign tap_code_o              = q.approximation_register;
  assign conversion_done_irq_o   = q.irq;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_sample_end;
    q.st == sadc_pkg::SADC_SAMPLE && q.cnt == 5'h00 && !wr_mode && !wr_sel;
  endsequence
  sequence s_first_trial;
    q.st == sadc_pkg::SADC_CONVERT && q.bit_idx == 4'h9 && q.approximation_register == 10'h200 && q.hold;
  endsequence
  sequence s_bit_decide;
    q.st == sadc_pkg::SADC_CONVERT && q.cnt == 5'h00 && q.bit_idx != 4'h0 && !wr_mode && !wr_sel;
  endsequence
  sequence s_next_trial;
    q.st == sadc_pkg::SADC_CONVERT && q.cnt != 5'h00 && q.bit_idx == 4'($past(q.bit_idx) - 4'h1);
  endsequence

  property p_irq_pulse;
    q.irq |=> !q.irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq wider than one cycle"); // see [RQ22]

  property p_result_low_zero;
    q.result[5:0] == 6'h00;
  endproperty
  a_result_low_zero: assert property (p_result_low_zero) else $error("result low bits set"); // see [RQ5]

  property p_write_wins;
    (wr_mode || wr_sel) |=> !q.irq && $stable(q.result);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("completion beat a write"); // see [RQ19]

  property p_write_restart;
    (wr_mode && wdata_i[7]) |=> q.st == sadc_pkg::SADC_SAMPLE && q.sample;
  endproperty
  a_write_restart: assert property (p_write_restart) else $error("no restart on write"); // see [RQ18]

  property p_disable;
    (wr_mode && !wdata_i[7]) |=> q.st == sadc_pkg::SADC_IDLE ##1 !q.irq;
  endproperty
  a_disable: assert property (p_disable) else $error("disable did not stop"); // see [RQ10]

  property p_mode_fixed_zero;
    (q.mode & 8'h47) == 8'h00;
  endproperty
  a_mode_fixed_zero: assert property (p_mode_fixed_zero) else $error("mode fixed bit set"); // see [RQ12]

  property p_msb_first;
    s_sample_end |=> s_first_trial;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("bad first trial"); // see [RQ4]

  property p_lsb_last;
    q.irq |-> $past(q.st) == sadc_pkg::SADC_CONVERT && $past(q.bit_idx) == 4'h0;
  endproperty
  a_lsb_last: assert property (p_lsb_last) else $error("load before lsb"); // see [RQ20]

  property p_sw_start_only;
    (q.st == sadc_pkg::SADC_IDLE && !wr_mode && !wr_sel) |=> q.st == sadc_pkg::SADC_IDLE;
  endproperty
  a_sw_start_only: assert property (p_sw_start_only) else $error("start without write"); // see [RQ2]

  property p_repeat;
    q.irq |-> q.st == sadc_pkg::SADC_SAMPLE && q.mode[7];
  endproperty
  a_repeat: assert property (p_repeat) else $error("no repeat after completion"); // see [RQ3]

  property p_hold_frozen;
    q.st == sadc_pkg::SADC_CONVERT |-> q.hold && !q.sample && $stable(q.sel);
  endproperty
  a_hold_frozen: assert property (p_hold_frozen) else $error("hold not frozen"); // see [RQ9]

  property p_slice_len;
    (q.st == sadc_pkg::SADC_SAMPLE && q.cnt == 5'h00 && !wr_mode && !wr_sel && q.mode[5:3] == 3'b110)
      |=> q.cnt == 5'h03;
  endproperty
  a_slice_len: assert property (p_slice_len) else $error("48-clock slice wrong"); // see [RQ21]

  // the slowest code needs the widest sample count
  property p_long_sample;
    (wr_mode && wdata_i[7] && wdata_i[5:3] == 3'b000) |=> q.cnt == 5'h17;
  endproperty
  a_long_sample: assert property (p_long_sample) else $error("144-clock sample wrong"); // see [RQ21]

  property p_bit_step;
    s_bit_decide |=> s_next_trial;
  endproperty
  a_bit_step: assert property (p_bit_step) else $error("bit step skipped"); // see [RQ20]

  property p_result_load;
    q.irq |-> q.result[15:6] == q.approximation_register && $past(push);
  endproperty
  a_result_load: assert property (p_result_load) else $error("irq without result load"); // see [RQ6]

  property p_read_old;
    (rd_en_i && addr_i == sadc_pkg::RESULT_ADDR) |=> q.rdata == $past(q.result);
  endproperty
  a_read_old: assert property (p_read_old) else $error("result read wrong"); // see [RQ8]

  property p_idle_quiet;
    q.st == sadc_pkg::SADC_IDLE |-> !q.sample && !q.hold && !q.irq;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle converter active"); // see [RQ10]

endmodule // sadc_top

// ===== rtl/sadc_pkg.sv
package sadc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [15:0] RESULT_ADDR     = 16'hFF14;
  localparam logic [15:0] RESULT_ADDR_HI  = 16'hFF15;
  localparam logic [15:0] MODE_ADDR       = 16'hFF80;
  localparam logic [15:0] SEL_ADDR        = 16'hFF84;

  localparam logic [15:0] RESULT_RESET    = 16'h0000;
  localparam logic [7:0]  MODE_RESET      = 8'h00;
  localparam logic [2:0]  SEL_RESET       = 3'h0;

  // ---------------------------------------------------------------
  // fields
  // ---------------------------------------------------------------
  localparam int          ENABLE_BIT      = 7;
  localparam int          TSEL_LSB        = 3;
  localparam int          TSEL_MSB        = 5;
  localparam logic [7:0]  MODE_WR_MASK    = 8'hB8;
  localparam int          SEL_MSB         = 2;
  localparam int          RES_BITS        = 10;
  localparam int          RES_LSB         = 6;
  localparam logic [9:0]  SAR_FIRST_TRIAL = 10'h200;
  localparam logic [3:0]  SAR_TOP_BIT     = 4'h9;

  // ---------------------------------------------------------------
  // timing, in main-clock periods
  // ---------------------------------------------------------------
  localparam logic [7:0]  CONV_CLK_000    = 8'd144;
  localparam logic [7:0]  CONV_CLK_001    = 8'd120;
  localparam logic [7:0]  CONV_CLK_010    = 8'd96;
  localparam logic [7:0]  CONV_CLK_100    = 8'd72;
  localparam logic [7:0]  CONV_CLK_101    = 8'd60;
  localparam logic [7:0]  CONV_CLK_110    = 8'd48;
  // one conversion = 2 sample slices + 10 bit slices
  localparam logic [7:0]  SLICES          = 8'd12;
  localparam logic [3:0]  SAMPLE_SLICES   = 4'd2;

  // ---------------------------------------------------------------
  // result buffer
  // ---------------------------------------------------------------
  localparam int          FIFO_WIDTH      = 16;
  localparam int          FIFO_DEPTH      = 16;

  typedef enum logic [1:0] {
    SADC_IDLE    = 2'b00,
    SADC_SAMPLE  = 2'b01,
    SADC_CONVERT = 2'b11
  } sadc_state_e;

  // prohibited codes fall back to the slowest setting
  function automatic logic [7:0] sadc_conv_clocks(input logic [2:0] code);
    unique case (code)
      3'b001:  sadc_conv_clocks = CONV_CLK_001;
      3'b010:  sadc_conv_clocks = CONV_CLK_010;
      3'b100:  sadc_conv_clocks = CONV_CLK_100;
      3'b101:  sadc_conv_clocks = CONV_CLK_101;
      3'b110:  sadc_conv_clocks = CONV_CLK_110;
      default: sadc_conv_clocks = CONV_CLK_000;
    endcase
  endfunction

  function automatic logic [3:0] sadc_slice_len(input logic [2:0] code);
    logic [7:0] q;
    q = sadc_conv_clocks(code) / SLICES;
    sadc_slice_len = q[3:0];
  endfunction

endpackage

// ===== rtl/sadc_fifo.sv
`timescale 1ns/10ps
module sadc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  // fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [PW:0]                 count;
    logic                        in_rdy;
    logic                        ov;
    logic [WIDTH-1:0]            od;
  } sadc_fifo_s;

  sadc_fifo_s q;
  sadc_fifo_s next_q;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic do_in;
    logic do_load;
    do_in   = 1'b0;
    do_load = 1'b0;
    next_q  = q;
    do_in   = in_valid_i && q.in_rdy;
    do_load = (q.count != '0) && (!q.ov || out_ready_i);
    if (q.ov && out_ready_i) begin
      next_q.ov = 1'b0;
    end
    if (do_load) begin
      next_q.od = q.mem[q.rd];
      next_q.ov = 1'b1;
      next_q.rd = PW'(q.rd + 1'b1);
    end
    if (do_in) begin
      next_q.mem[q.wr] = in_data_i;
      next_q.wr        = PW'(q.wr + 1'b1);
    end
    next_q.count  = (PW+1)'(q.count + {PW'(0), do_in} - {PW'(0), do_load});
    // registered ready: full storage stalls the source next cycle
    next_q.in_rdy = next_q.count < (PW+1)'(DEPTH);
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q        <= '0;
      q.in_rdy <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign in_ready_o  = q.in_rdy;
  assign out_valid_o = q.ov;
  assign out_data_o  = q.od;

endmodule // sadc_fifo

// ===== testbench/sadc_analog_model.sv
`timescale 1ns/10ps
module sadc_analog_model (
  // clock
  input  wire logic       mclk_i,
  // converter side
  input  wire logic [2:0] chan_i,
  input  wire logic       sample_i,
  input  wire logic       hold_i,
  input  wire logic [9:0] tap_i,
  // pin levels, one per analog input channel
  input  wire logic [9:0] level_i [8],
  output logic            cmp_o
);
  logic [9:0] held;
  logic       junk = 1'b0;

  // capacitor tracks the pin only while sampling, frozen otherwise
  always @(posedge mclk_i) begin
    if (sample_i) begin
      held <= level_i[chan_i];
    end
    junk <= ~junk;
  end

  // outside the decision phase the output means nothing, so it toggles
  assign cmp_o = hold_i ? (held >= tap_i) : junk;
endmodule // sadc_analog_model

// ===== testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic        wr_en_i = 1'b0;
  logic [7:0]  wdata_i = 8'h00;
  logic        rd_en_i = 1'b0;
  logic        result_ready_i = 1'b1;
  logic [15:0] rdata_o;
  logic [15:0] result_data_o;
  logic [15:0] exp_res;
  logic [2:0]  chan;
  logic [9:0]  tap;
  logic [9:0]  lvl [8];
  logic        sample, hold, cmp, irq, result_valid_o;
  int          fails = 0;
  int          n_checks = 0;
  int          irq_cnt = 0;
  int          cycles = 0;
  localparam logic [7:0] conv_n [8] = '{8'h90, 8'h78, 8'h60, 8'h90,
                                        8'h48, 8'h3C, 8'h30, 8'h90};

  sadc_top DUT (
    .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_en_i(wr_en_i),
    .wdata_i(wdata_i), .rd_en_i(rd_en_i), .rdata_o(rdata_o),
    .analog_input_channels_o(chan), .sample_o(sample), .hold_o(hold),
    .tap_code_o(tap), .cmp_i(cmp), .conversion_done_irq_o(irq),
    .result_valid_o(result_valid_o), .result_data_o(result_data_o),
    .result_ready_i(result_ready_i)
  );

  sadc_analog_model pins (
    .mclk_i(mclk_i), .chan_i(chan), .sample_i(sample), .hold_i(hold),
    .tap_i(tap), .level_i(lvl), .cmp_o(cmp)
  );

  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  // counted mid-cycle so a pulse is seen exactly once
  always @(negedge mclk_i) begin
    if (irq === 1'b1) begin
      irq_cnt++;
    end
  end

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 10000) begin
      fails++;
      print_verdict();
    end
  end

  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    #1;
    addr_i = a;
    wdata_i = d;
    wr_en_i = 1'b1;
    @(posedge mclk_i);
    #1;
    wr_en_i = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge mclk_i);
    #1;
    addr_i = a;
    rd_en_i = 1'b1;
    @(posedge mclk_i);
    #1;
    rd_en_i = 1'b0;
    v = rdata_o;
  endtask

  // bounded so a missing pulse cannot hang the run
  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(posedge mclk_i);
      #1;
      n++;
    end while (irq !== 1'b1 && n < 400);
    chk({15'h0000, irq}, 16'h0001);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin : main
    logic [15:0] v;
    int n;
    int c0;
    int k;
    for (k = 0; k < 8; k++) begin
      lvl[k] = 10'h02B + 10'(k) * 10'h085;
    end
    repeat (2) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    rd(sadc_pkg::RESULT_ADDR, v);
    chk(v, 16'h0000);
    rd(sadc_pkg::MODE_ADDR, v);
    chk(v, 16'h0000);
    rd(sadc_pkg::SEL_ADDR, v);
    chk(v, 16'h0000);
    rd(16'h1234, v);
    chk(v, 16'h0000);
    chk({13'h0000, chan}, 16'h0000);
    wr(sadc_pkg::MODE_ADDR, 8'h47);
    wr(sadc_pkg::RESULT_ADDR, 8'h5A);
    repeat (200) @(posedge mclk_i);
    chk(16'(irq_cnt), 16'h0000);
    rd(sadc_pkg::MODE_ADDR, v);
    chk(v, 16'h0000);
    rd(sadc_pkg::RESULT_ADDR, v);
    chk(v, 16'h0000);
    // every time code, each on its own channel
    for (k = 0; k < 8; k++) begin
      wr(sadc_pkg::SEL_ADDR, 8'(k));
      chk({13'h0000, chan}, 16'(k));
      // clock is far above 10 MHz, so the fast codes are legal here
      wr(sadc_pkg::MODE_ADDR, 8'h80 | 8'(k << 3));
      chk({14'h0000, sample, hold}, 16'h0002);
      wait_irq(n);
      chk(16'(n), {8'h00, conv_n[k]});
      @(posedge mclk_i);
      #1;
      chk({15'h0000, irq}, 16'h0000);
      // first result after enabling is thrown away
      wait_irq(n);
      chk(16'(n), {8'h00, conv_n[k]} - 16'h0001);
      chk({6'h00, tap}, {6'h00, lvl[k]});
      rd(sadc_pkg::RESULT_ADDR, v);
      chk(v, {lvl[k], 6'h00});
      rd(sadc_pkg::MODE_ADDR, v);
      chk(v, {8'h00, 8'h80 | 8'(k << 3)});
    end
    // cancel mid-way and on the very edge that would complete
    exp_res = {lvl[7], 6'h00};
    lvl[7] = ~lvl[7];
    for (k = 18; k < 48; k += 28) begin
      wr(sadc_pkg::SEL_ADDR, 8'h07);
      wr(sadc_pkg::MODE_ADDR, 8'hB0);
      c0 = irq_cnt;
      repeat (k) @(posedge mclk_i);
      wr(sadc_pkg::SEL_ADDR, 8'h02);
      chk({15'h0000, irq}, 16'h0000);
      chk(16'(irq_cnt - c0), 16'h0000);
      rd(sadc_pkg::RESULT_ADDR, v);
      chk(v, exp_res);
      // restart counts from the abort edge; the read used two of its edges
      wait_irq(n);
      chk(16'(n), {8'h00, sadc_pkg::CONV_CLK_110} - 16'h0002);
      exp_res = {lvl[2], 6'h00};
    end
    wr(sadc_pkg::MODE_ADDR, 8'h30);
    c0 = irq_cnt;
    repeat (300) @(posedge mclk_i);
    chk(16'(irq_cnt - c0), 16'h0000);
    // fill the buffer with the drain stalled, then empty it
    #1;
    result_ready_i = 1'b0;
    wr(sadc_pkg::MODE_ADDR, 8'hB0);
    c0 = irq_cnt;
    repeat (1500) @(posedge mclk_i);
    c0 = irq_cnt - c0;
    // storage plus the output stage, then the sequencer stalls
    chk(16'(c0), 16'(sadc_pkg::FIFO_DEPTH + 1));
    wr(sadc_pkg::MODE_ADDR, 8'h30);
    result_ready_i = 1'b1;
    n = 0;
    repeat (40) begin
      if (result_valid_o === 1'b1) begin
        n++;
        chk(result_data_o, {lvl[2], 6'h00});
      end
      @(posedge mclk_i);
      #1;
    end
    chk(16'(n), 16'(c0));
    chk({15'h0000, result_valid_o}, 16'h0000);
    print_verdict();
  end
endmodule // testbench
